// [hdl/cpp_pkg.sv]
// ==========================================================
// Shared constants for the coprocessor pipeline port
package cpp_pkg;
  localparam int DATA_W     = 32;
  localparam int BURST_W    = 4;
  localparam int HS_W       = 2;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // Instruction fields that mark a coprocessor load or store, reset word and burst counts
  localparam int                 XFER_OPC_LSB = 25;
  localparam int                 LOAD_BIT     = 20;
  localparam logic [2:0]         XFER_OPC     = 3'h6;
  localparam logic [DATA_W-1:0]  RST_WORD     = 32'h0000_0000;
  localparam logic [BURST_W-1:0] BURST_NONE   = 4'h0;
  localparam logic [BURST_W-1:0] BURST_ONE    = 4'h1;

  // ==========================================================
  // Handshake codes, shared by decode and execute stage
  typedef enum logic [HS_W-1:0] {
    HS_WAIT   = 2'b00,
    HS_GO     = 2'b01,
    HS_ABSENT = 2'b10,
    HS_LAST   = 2'b11
  } cpp_hs_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DECODE   = 3'b001,
    ST_EXECUTE  = 3'b010,
    ST_MEMORY   = 3'b011,
    ST_TRANSFER = 3'b100,
    ST_WBACK    = 3'b101
  } cpp_state_t;
endpackage : cpp_pkg

// [hdl/cpp_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Word stream with valid and ready
interface cpp_stream_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cpp_stream_if
`default_nettype wire

// [hdl/cpp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic   core_clk,
  input  wire logic   reset_n,
  input  wire logic   ce,
  cpp_stream_if.snk   inIf,
  cpp_stream_if.src   outIf
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             notFull;
  logic             notEmpty;
  wire              push = ce && inIf.valid && notFull;
  wire              pop  = ce && outIf.ready && notEmpty;

  // ==========================================================
  // Flags are flops so the top sees registered ready/valid
  assign inIf.ready  = notFull;
  assign outIf.valid = notEmpty;
  assign outIf.data  = mem[rdPtr];
  assign next_count  = count + CW'(push) - CW'(pop);

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge core_clk) begin
        if (push && wrPtr == PW'(i)) begin
          mem[i] <= inIf.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      notFull  <= 1'b1;
      notEmpty <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
      end
      count    <= next_count;
      notFull  <= next_count != CW'(DEPTH);
      notEmpty <= next_count != '0;
    end
  end
endmodule : cpp_fifo
`default_nettype wire

// [hdl/cpp_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Everything on rising core clock, inputs synchronous except asynchronous reset_n
// - Abort output asserted in write-back stage
// - Follower advances only with enable high
// - Device drives outgoing data bus
// - Interface enable low disables the interface
// - Instruction sent over instruction bus
// - Pass asserted for executing instruction
// - Decode codes absent/wait/go/last
// - Execute handshake uses same codes
// - Active-low valid qualifies instruction bus
// - Privilege output low means nonprivileged
module cpp_port #(
  parameter int DATA_W     = cpp_pkg::DATA_W,
  parameter int BURST_W    = cpp_pkg::BURST_W,
  parameter int FIFO_DEPTH = cpp_pkg::FIFO_DEPTH
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  input  wire logic               coreInstrValid,
  input  wire logic [DATA_W-1:0]  coreInstr,
  input  wire logic               corePrivileged,
  input  wire logic               coreCondPass,
  input  wire logic               coreLateCancel,
  input  wire logic               coreAbort,
  input  wire logic               coreStall,
  output logic                    coreInstrReady,
  output logic                    coreUndefined,
  input  wire logic               storeValid,
  input  wire logic [DATA_W-1:0]  storeData,
  output logic                    storeReady,
  output logic                    loadValid,
  output logic [DATA_W-1:0]       loadData,
  input  wire logic               cop_interface_enable,
  input  wire logic [1:0]         cop_decode_handshake,
  input  wire logic [1:0]         cop_execute_handshake,
  input  wire logic [BURST_W-1:0] cop_burst_word_count,
  input  wire logic [DATA_W-1:0]  cop_to_core_data,
  output logic [DATA_W-1:0]       core_to_cop_data,
  output logic [DATA_W-1:0]       cop_instruction_bus,
  output logic                    cop_instr_valid_n,
  output logic                    cop_instr_request_n,
  output logic                    cop_follower_advance_en,
  output logic                    cop_execute_pass,
  output logic                    cop_late_cancel,
  output logic                    cop_transfer_abort,
  output logic                    cop_privilege_n
);
  cpp_pkg::cpp_state_t state;
  cpp_pkg::cpp_state_t next_state;
  logic [BURST_W-1:0]  wordsLeft;
  logic                isXfer;
  logic                isLoad;

  cpp_stream_if #(.WIDTH(DATA_W)) storeIn ();
  cpp_stream_if #(.WIDTH(DATA_W)) storeOut ();

  // ==========================================================
  // Store data buffer; core is held off through storeReady
  assign storeIn.valid = storeValid;
  assign storeIn.data  = storeData;
  assign storeReady    = storeIn.ready;

  cpp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_store_fifo (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .inIf     (storeIn),
    .outIf    (storeOut)
  );

  // ==========================================================
  // Decode of progress conditions
  wire step      = ce && cop_follower_advance_en;
  wire issue     = state == cpp_pkg::ST_IDLE && coreInstrValid && cop_interface_enable;
  wire offIssue  = state == cpp_pkg::ST_IDLE && coreInstrValid && !cop_interface_enable;
  wire newXfer   = coreInstr[cpp_pkg::XFER_OPC_LSB +: 3] == cpp_pkg::XFER_OPC;
  wire storing   = state == cpp_pkg::ST_TRANSFER && !isLoad;
  wire beat      = state == cpp_pkg::ST_TRANSFER && (isLoad || storeOut.valid);
  wire deAbsent  = cop_decode_handshake == cpp_pkg::HS_ABSENT;
  wire deWait    = cop_decode_handshake == cpp_pkg::HS_WAIT;
  wire exAbsent  = cop_execute_handshake == cpp_pkg::HS_ABSENT;
  wire exWait    = cop_execute_handshake == cpp_pkg::HS_WAIT;
  // Starving the follower of store data would hand it stale words
  wire starve    = next_state == cpp_pkg::ST_TRANSFER && !isLoad && !storeOut.valid;
  wire undefNow  = offIssue || (state == cpp_pkg::ST_DECODE && deAbsent)
                   || (state == cpp_pkg::ST_EXECUTE && cop_execute_pass && exAbsent);
  assign storeOut.ready = step && storing;

  always_comb begin
    next_state = state;
    case (state)
      cpp_pkg::ST_IDLE: begin
        if (issue) begin
          next_state = cpp_pkg::ST_DECODE;
        end
      end
      cpp_pkg::ST_DECODE: begin
        if (deAbsent) begin
          next_state = cpp_pkg::ST_IDLE;
        end else if (!deWait) begin
          next_state = cpp_pkg::ST_EXECUTE;
        end
      end
      cpp_pkg::ST_EXECUTE: begin
        if (!cop_execute_pass || exAbsent) begin
          next_state = cpp_pkg::ST_IDLE;
        end else if (!exWait) begin
          next_state = cpp_pkg::ST_MEMORY;
        end
      end
      cpp_pkg::ST_MEMORY: begin
        if (cop_late_cancel) begin
          next_state = cpp_pkg::ST_IDLE;
        end else if (isXfer && cop_burst_word_count != cpp_pkg::BURST_NONE) begin
          next_state = cpp_pkg::ST_TRANSFER;
        end else begin
          next_state = cpp_pkg::ST_WBACK;
        end
      end
      cpp_pkg::ST_TRANSFER: begin
        if (beat && wordsLeft == cpp_pkg::BURST_ONE) begin
          next_state = cpp_pkg::ST_WBACK;
        end
      end
      default: next_state = cpp_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // Pipeline and pin registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state                   <= cpp_pkg::ST_IDLE;
      wordsLeft               <= cpp_pkg::BURST_NONE;
      isXfer                  <= 1'b0;
      isLoad                  <= 1'b0;
      coreInstrReady          <= 1'b0;
      coreUndefined           <= 1'b0;
      loadValid               <= 1'b0;
      loadData                <= cpp_pkg::RST_WORD;
      core_to_cop_data        <= cpp_pkg::RST_WORD;
      cop_instruction_bus     <= cpp_pkg::RST_WORD;
      cop_instr_valid_n       <= 1'b1;
      cop_instr_request_n     <= 1'b1;
      cop_follower_advance_en <= 1'b0;
      cop_execute_pass        <= 1'b0;
      cop_late_cancel         <= 1'b0;
      cop_transfer_abort      <= 1'b0;
      cop_privilege_n         <= 1'b0;
    end else if (ce) begin
      cop_follower_advance_en <= !coreStall && !starve;
      coreInstrReady          <= next_state == cpp_pkg::ST_IDLE && step
                                 || state == cpp_pkg::ST_IDLE && !step;
      coreUndefined           <= step && undefNow;
      loadValid               <= step && beat && isLoad;
      cop_transfer_abort      <= step && state == cpp_pkg::ST_WBACK && isXfer && coreAbort;
      if (step) begin
        state               <= next_state;
        cop_instr_request_n <= !issue;
        cop_instr_valid_n   <= !issue;
        cop_execute_pass    <= next_state == cpp_pkg::ST_EXECUTE
                               && (state == cpp_pkg::ST_EXECUTE ? cop_execute_pass : coreCondPass);
        cop_late_cancel     <= next_state == cpp_pkg::ST_MEMORY && coreLateCancel;
        if (issue) begin
          cop_instruction_bus <= coreInstr;
          cop_privilege_n     <= corePrivileged;
          isXfer              <= newXfer;
          isLoad              <= coreInstr[cpp_pkg::LOAD_BIT];
        end
        if (next_state == cpp_pkg::ST_TRANSFER && state == cpp_pkg::ST_MEMORY) begin
          wordsLeft <= cop_burst_word_count;
        end else if (beat) begin
          wordsLeft <= wordsLeft - cpp_pkg::BURST_ONE;
        end
        if (beat && !isLoad) begin
          core_to_cop_data <= storeOut.data;
        end
        if (beat && isLoad) begin
          loadData <= cop_to_core_data;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_abort_wback: assert property (
    cop_transfer_abort |-> $past(state) == cpp_pkg::ST_WBACK && $past(coreAbort) && isXfer)
    else $error("abort outside write-back");
  chk_advance_freeze: assert property (
    !cop_follower_advance_en && ce |=> $stable(state) && $stable(cop_instr_request_n))
    else $error("pipeline moved without advance enable");
  chk_disabled_noissue: assert property (
    step && offIssue |=> cop_instr_request_n && coreUndefined)
    else $error("instruction issued while interface disabled");
  chk_pass_execute: assert property (
    cop_execute_pass |-> state == cpp_pkg::ST_EXECUTE)
    else $error("pass outside execute stage");
  chk_cancel_memory: assert property (
    cop_late_cancel && step |=> state == cpp_pkg::ST_IDLE && !cop_late_cancel)
    else $error("late cancel did not drop instruction");
  chk_decode_absent: assert property (
    step && state == cpp_pkg::ST_DECODE && deAbsent |=> coreUndefined && state == cpp_pkg::ST_IDLE)
    else $error("absent decode handshake not reported");
  chk_execute_wait: assert property (
    step && state == cpp_pkg::ST_EXECUTE && cop_execute_pass && exWait |=> state == cpp_pkg::ST_EXECUTE)
    else $error("execute wait not honoured");
  chk_valid_request: assert property (
    !cop_instr_request_n |-> !cop_instr_valid_n && state == cpp_pkg::ST_DECODE)
    else $error("request without valid instruction");
  chk_privilege_issue: assert property (
    step && issue |=> cop_privilege_n == $past(corePrivileged) && cop_instruction_bus == $past(coreInstr))
    else $error("privilege or instruction not captured at issue");
  chk_burst_count: assert property (
    step && beat && state == cpp_pkg::ST_TRANSFER && wordsLeft > cpp_pkg::BURST_ONE
    |=> wordsLeft == $past(wordsLeft) - cpp_pkg::BURST_ONE)
    else $error("burst count not decremented");
endmodule : cpp_port
`default_nettype wire

// [dv/cpp_cop_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Coprocessor follower model
module cpp_cop_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic [1:0]  cfgDecode,
  input  wire logic [1:0]  cfgExecute,
  input  wire logic [3:0]  cfgBurst,
  input  wire logic [3:0]  cfgSlow,
  input  wire logic        advanceEn,
  input  wire logic        requestN,
  output logic [1:0]       decodeHs,
  output logic [1:0]       executeHs,
  output logic [3:0]       burst,
  output logic [31:0]      dataOut
);
  logic [3:0]  waitCnt;
  logic [31:0] index;
  // Request edge counts as step zero of the decode stage
  wire logic [3:0] reqAge = requestN ? waitCnt : 4'h0;
  // Moves only on enabled edges, so a frozen follower keeps its word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 4'h0;
      index   <= 32'h0000_0000;
    end else if (advanceEn) begin
      index <= index + 32'h0000_0001;
      if (!requestN) waitCnt <= 4'h1;
      else if (waitCnt != 4'hF) waitCnt <= waitCnt + 4'h1;
    end
  end
  assign decodeHs  = !enable ? cpp_pkg::HS_ABSENT : (reqAge < cfgSlow) ? cpp_pkg::HS_WAIT : cfgDecode;
  // Execute stalls about as long as decode did, so both wait paths get used
  assign executeHs = !enable ? cpp_pkg::HS_ABSENT
                     : (waitCnt < {cfgSlow[2:0], 1'b0}) ? cpp_pkg::HS_WAIT : cfgExecute;
  assign burst     = enable ? cfgBurst : 4'h0;
  // Word changes every step, so a stale sample shows up as a gap
  assign dataOut   = 32'hD000_0000 + index;
endmodule : cpp_cop_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk, reset_n, ce, coreInstrValid, corePrivileged, coreCondPass;
  logic        coreLateCancel, coreAbort, coreStall, storeValid, cop_interface_enable;
  logic [31:0] coreInstr, storeData, loadData, core_to_cop_data, cop_instruction_bus, cop_to_core_data;
  logic        coreInstrReady, coreUndefined, storeReady, loadValid, cop_instr_valid_n, cop_instr_request_n;
  logic        cop_follower_advance_en, cop_execute_pass, cop_late_cancel, cop_transfer_abort, cop_privilege_n;
  logic [1:0]  cop_decode_handshake, cop_execute_handshake, cfgDecode, cfgExecute;
  logic [3:0]  cop_burst_word_count, cfgBurst, cfgSlow;
  int          errors, checks, takenCnt, loadCnt, loadBad;
  logic        sawPass, sawCancel, sawAbort, sawUndef, takenValidN, takenPriv;
  logic [31:0] takenBus, lastLoad, lastStore;
  logic [31:0] storeSeen[$];

  cpp_port dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .coreInstrValid(coreInstrValid),
    .coreInstr(coreInstr), .corePrivileged(corePrivileged), .coreCondPass(coreCondPass),
    .coreLateCancel(coreLateCancel), .coreAbort(coreAbort), .coreStall(coreStall),
    .coreInstrReady(coreInstrReady), .coreUndefined(coreUndefined), .storeValid(storeValid),
    .storeData(storeData), .storeReady(storeReady), .loadValid(loadValid), .loadData(loadData),
    .cop_interface_enable(cop_interface_enable), .cop_decode_handshake(cop_decode_handshake),
    .cop_execute_handshake(cop_execute_handshake), .cop_burst_word_count(cop_burst_word_count),
    .cop_to_core_data(cop_to_core_data), .core_to_cop_data(core_to_cop_data),
    .cop_instruction_bus(cop_instruction_bus), .cop_instr_valid_n(cop_instr_valid_n),
    .cop_instr_request_n(cop_instr_request_n), .cop_follower_advance_en(cop_follower_advance_en),
    .cop_execute_pass(cop_execute_pass), .cop_late_cancel(cop_late_cancel),
    .cop_transfer_abort(cop_transfer_abort), .cop_privilege_n(cop_privilege_n));

  cpp_cop_model partner (.core_clk(core_clk), .reset_n(reset_n), .enable(cop_interface_enable),
    .cfgDecode(cfgDecode), .cfgExecute(cfgExecute), .cfgBurst(cfgBurst), .cfgSlow(cfgSlow),
    .advanceEn(cop_follower_advance_en), .requestN(cop_instr_request_n),
    .decodeHs(cop_decode_handshake), .executeHs(cop_execute_handshake),
    .burst(cop_burst_word_count), .dataOut(cop_to_core_data));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Port monitor, sampled on every rising edge
  always @(posedge core_clk) begin
    if (cop_instr_request_n === 1'b0 && cop_follower_advance_en === 1'b1) begin
      takenCnt++;
      takenBus = cop_instruction_bus;
      takenValidN = cop_instr_valid_n;
      takenPriv = cop_privilege_n;
    end
    if (cop_execute_pass === 1'b1) sawPass = 1'b1;
    if (cop_late_cancel === 1'b1) sawCancel = 1'b1;
    if (cop_transfer_abort === 1'b1) sawAbort = 1'b1;
    if (coreUndefined === 1'b1) sawUndef = 1'b1;
    if (loadValid === 1'b1) begin
      if (loadCnt > 0 && loadData !== lastLoad + 32'h0000_0001) loadBad++;
      lastLoad = loadData;
      loadCnt++;
    end
    if (core_to_cop_data !== lastStore) begin
      storeSeen.push_back(core_to_cop_data);
      lastStore = core_to_cop_data;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic run_op(input logic [31:0] instr, input logic [1:0] dec, input logic [1:0] ex,
                        input logic [3:0] bst, input logic cond);
    int n;
    cfgDecode = dec;
    cfgExecute = ex;
    cfgBurst = bst;
    coreInstr = instr;
    coreCondPass = cond;
    {takenCnt, loadCnt, loadBad} = '0;
    {sawPass, sawCancel, sawAbort, sawUndef} = '0;
    storeSeen.delete();
    coreInstrValid = 1'b1;
    if (coreStall) begin
      repeat (6) @(posedge core_clk);
      #1;
      check("advance_stalled", cop_follower_advance_en, 32'h0);
      check("taken_stalled", takenCnt, 32'h0);
      coreStall = 1'b0;
    end
    for (n = 0; n < 100 && coreUndefined !== 1'b1 && coreInstrReady !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    // Never taken counts as a hang as well
    if (n >= 100) n = 300;
    coreInstrValid = 1'b0;
    for (n = n; n < 300 && coreInstrReady !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n >= 300) begin
      errors++;
      report_and_stop();
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask : run_op

  // ==========================================================
  // Scenarios
  task automatic sc_reset;
    check("valid_n_rst", cop_instr_valid_n, 32'h1);
    check("request_n_rst", cop_instr_request_n, 32'h1);
    check("advance_rst", cop_follower_advance_en, 32'h0);
    check("abort_rst", cop_transfer_abort, 32'h0);
    reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("advance_run", cop_follower_advance_en, 32'h1);
    check("ready_run", coreInstrReady, 32'h1);
  endtask : sc_reset

  task automatic sc_codes;
    // Every go/last pairing, with growing decode waits
    for (int i = 0; i < 4; i++) begin
      corePrivileged = i[0];
      cfgSlow = i[3:0];
      run_op(32'h0E00_0010 + i, i[0] ? cpp_pkg::HS_LAST : cpp_pkg::HS_GO,
             i[1] ? cpp_pkg::HS_LAST : cpp_pkg::HS_GO, 4'h0, 1'b1);
      check("taken", takenCnt, 32'h1);
      check("instr_bus", takenBus, 32'h0E00_0010 + i);
      check("valid_n", takenValidN, 32'h0);
      check("privilege_n", takenPriv, i[0]);
      check("pass", sawPass, 32'h1);
    end
    cfgSlow = 4'h0;
    run_op(32'h0E00_0020, cpp_pkg::HS_GO, cpp_pkg::HS_GO, 4'h0, 1'b0);
    check("no_pass", sawPass, 32'h0);
    run_op(32'h0E00_0030, cpp_pkg::HS_ABSENT, cpp_pkg::HS_GO, 4'h0, 1'b1);
    check("dec_absent", sawUndef, 32'h1);
    run_op(32'h0E00_0040, cpp_pkg::HS_GO, cpp_pkg::HS_ABSENT, 4'h0, 1'b1);
    check("ex_absent", sawUndef, 32'h1);
  endtask : sc_codes

  task automatic sc_disabled;
    cop_interface_enable = 1'b0;
    run_op(32'h0E00_0050, cpp_pkg::HS_GO, cpp_pkg::HS_GO, 4'h3, 1'b1);
    check("dis_undef", sawUndef, 32'h1);
    check("dis_taken", takenCnt, 32'h0);
    cop_interface_enable = 1'b1;
  endtask : sc_disabled

  task automatic sc_load;
    int b;
    coreLateCancel = 1'b1;
    run_op(32'h0C10_0000, cpp_pkg::HS_GO, cpp_pkg::HS_LAST, 4'h2, 1'b1);
    check("cancel", sawCancel, 32'h1);
    check("cancel_loads", loadCnt, 32'h0);
    coreLateCancel = 1'b0;
    // Zero, single and multi-word bursts; abort only on the long one
    for (int k = 0; k < 3; k++) begin
      b = (k == 2) ? 4 : k;
      coreAbort = (k == 2);
      run_op(32'h0C10_0000, cpp_pkg::HS_GO, cpp_pkg::HS_GO, b[3:0], 1'b1);
      check("load_count", loadCnt, b);
      check("load_gaps", loadBad, 32'h0);
      check("abort", sawAbort, k == 2);
    end
    coreAbort = 1'b0;
  endtask : sc_load

  task automatic sc_store;
    for (int k = 0; k < 8; k++) begin
      storeValid = 1'b1;
      storeData = 32'h5100_0000 + k;
      @(posedge core_clk);
      #1;
    end
    storeValid = 1'b0;
    check("fifo_full", storeReady, 32'h0);
    cfgSlow = 4'h3;
    run_op(32'h0C00_0000, cpp_pkg::HS_GO, cpp_pkg::HS_GO, 4'h8, 1'b1);
    check("store_beats", storeSeen.size(), 32'h8);
    foreach (storeSeen[k]) check("store_word", storeSeen[k], 32'h5100_0000 + k);
    check("fifo_empty", storeReady, 32'h1);
    cfgSlow = 4'h0;
  endtask : sc_store

  task automatic sc_stall;
    coreStall = 1'b1;
    run_op(32'h0E00_0060, cpp_pkg::HS_GO, cpp_pkg::HS_GO, 4'h0, 1'b1);
    check("after_stall", takenCnt, 32'h1);
  endtask : sc_stall

  task automatic sc_freeze;
    // Clock enable low must keep an offered instruction off the port
    takenCnt = 0;
    ce = 1'b0;
    coreInstr = 32'h0E00_0070;
    coreInstrValid = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check("frozen_taken", takenCnt, 32'h0);
    check("frozen_ready", coreInstrReady, 32'h1);
    ce = 1'b1;
    run_op(32'h0E00_0070, cpp_pkg::HS_GO, cpp_pkg::HS_GO, 4'h0, 1'b1);
    check("thawed_taken", takenCnt, 32'h1);
  endtask : sc_freeze

  initial begin
    {ce, cop_interface_enable} = 2'h3;
    {reset_n, coreInstrValid, corePrivileged, coreCondPass} = '0;
    {coreLateCancel, coreAbort, coreStall, storeValid} = '0;
    {coreInstr, storeData, lastLoad, lastStore} = '0;
    {cfgDecode, cfgExecute, cfgBurst, cfgSlow} = '0;
    {errors, checks, takenCnt, loadCnt, loadBad} = '0;
    {sawPass, sawCancel, sawAbort, sawUndef, takenValidN, takenPriv, takenBus} = '0;
    repeat (16) @(posedge core_clk);
    #1;
    sc_reset();
    sc_codes();
    sc_disabled();
    sc_load();
    sc_store();
    sc_stall();
    sc_freeze();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
